/* File: nco_pkg.sv */
// Package with register map, field layout and state record of the oscillator.
package nco_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [4:0] NCO_OFS_CTRL      = 5'h00;
    localparam logic [4:0] NCO_OFS_CLKSEL    = 5'h04;
    localparam logic [4:0] NCO_OFS_ACC_LOW   = 5'h08;
    localparam logic [4:0] NCO_OFS_ACC_HIGH  = 5'h0c;
    localparam logic [4:0] NCO_OFS_ACC_UPPER = 5'h10;
    localparam logic [4:0] NCO_OFS_STEP_LOW  = 5'h14;
    localparam logic [4:0] NCO_OFS_STEP_HIGH = 5'h18;
    localparam logic [4:0] NCO_OFS_IRQ       = 5'h1c;

    // Control register field positions.
    localparam int NCO_CTRL_EN  = 7;
    localparam int NCO_CTRL_OE  = 6;
    localparam int NCO_CTRL_OUT = 5;
    localparam int NCO_CTRL_POL = 4;
    localparam int NCO_CTRL_PFM = 0;

    // Clock select register field positions.
    localparam int NCO_CLK_PWS_LSB = 5;
    localparam int NCO_CLK_CKS_LSB = 0;

    // Interrupt register field positions.
    localparam int NCO_IRQ_FLAG = 0;
    localparam int NCO_IRQ_IE   = 1;
    localparam int NCO_IRQ_PERIPHERAL_IRQ_ENABLE = 2;
    localparam int NCO_IRQ_GIE  = 3;

    // Clock source select codes.
    localparam logic [1:0] NCO_SRC_HFOSC = 2'h0;
    localparam logic [1:0] NCO_SRC_FOSC  = 2'h1;
    localparam logic [1:0] NCO_SRC_LC    = 2'h2;
    localparam logic [1:0] NCO_SRC_EXT   = 2'h3;

    // Widths and reset values.
    localparam int          NCO_ACC_W     = 20;
    localparam int          NCO_STEP_W    = 16;
    localparam logic [31:0] NCO_RDATA_RST = 32'h0000_0000;

    // Complete state of the oscillator, registered as one record.
    typedef struct packed {
        logic [1:0]  hf_sync;
        logic [1:0]  lc_sync;
        logic [1:0]  ext_sync;
        logic        src_prev;
        logic        en;
        logic        oe;
        logic        pol;
        logic        pfm;
        logic [2:0]  pws;
        logic [1:0]  cks;
        logic [19:0] acc;
        logic [15:0] step_buf;
        logic [15:0] step_act;
        logic        step_pend;
        logic        ovf_pend;
        logic        pulse_act;
        logic [6:0]  pulse_cnt;
        logic        toggle;
        logic        level;
        logic        flag;
        logic        ie;
        logic        peripheral_irq_enable;
        logic        global_irq_enable;
        logic        wait_r;
        logic [31:0] rdata;
        logic        irq;
        logic        pin;
        logic        pin_oe;
        logic        keep_hf;
    } nco_state_t;

endpackage

/* File: nco_top.sv */
// Phase-accumulator oscillator with Avalon-MM register access.
`timescale 1ns/100ps
// Behaviour
// - 20-bit accumulator in three byte registers
// - Each input clock edge adds increment while enabled
// - Increment from low and high bytes
// - Accumulator carry is the raw output
// - Four input clock sources, 2-bit select
// - Select codes: hf, fosc, logic cell, ext
// - Disabled: increment writes take effect immediately
// - Enabled: load after low byte, synchronously
// - Fixed duty mode toggles on overflow
// - Mode bit picks fixed duty or pulse
// - Pulse starts on edge after overflow
// - Pulse width from 3-bit field
// - Width is two to field power periods
// - Polarity stage follows mode logic
// - Polarity one active high, zero low
// - Polarity change interrupts when enabled
// - Read-only bit shows output level
// - Output goes to peripherals, pin gated
// - Pin driven only when output enable bit set
// - Overflow sets the interrupt flag
// - Request needs all four enables set
// - Flag stays set until software clears
// - Reset clears every register to zero but the level bit and wait_r, set to one
// - Runs from own clock during sleep
// - Keep hf oscillator on when selected and enabled
module nco_top (
    // Clock and reset.
    input  wire logic        sys_clk_in,
    input  wire logic        reset_n_in,
    // Avalon-MM slave.
    input  wire logic [4:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // Oscillator clock sources from outside this domain.
    input  wire logic        high_freq_internal_osc_in,
    input  wire logic        logic_cell_output_in,
    input  wire logic        external_clock_pin_in,
    // Outputs to peripherals, pin, interrupt logic and the hf oscillator.
    output logic             output_level_out,
    output logic             pin_out,
    output logic             pin_oe_out,
    output logic             irq_request_out,
    output logic             hf_osc_keep_on_out
);

    nco_pkg::nco_state_t q;
    nco_pkg::nco_state_t d;

    logic        tick;
    logic        src_now;
    logic        wr_go;
    logic        rd_go;
    logic        wr_lane;
    logic [7:0]  wbyte;
    logic [20:0] sum_w;
    logic        carry;
    logic        acc_wr;
    logic        step_wr;
    logic        flag_clr;

    // Reads one register as a zero-padded word.
    function automatic logic [31:0] reg_read(input nco_pkg::nco_state_t s,
                                             input logic [4:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            nco_pkg::NCO_OFS_CTRL: begin
                v[nco_pkg::NCO_CTRL_EN]  = s.en;
                v[nco_pkg::NCO_CTRL_OE]  = s.oe;
                v[nco_pkg::NCO_CTRL_OUT] = s.level;
                v[nco_pkg::NCO_CTRL_POL] = s.pol;
                v[nco_pkg::NCO_CTRL_PFM] = s.pfm;
            end
            nco_pkg::NCO_OFS_CLKSEL: begin
                v[nco_pkg::NCO_CLK_PWS_LSB +: 3] = s.pws;
                v[nco_pkg::NCO_CLK_CKS_LSB +: 2] = s.cks;
            end
            nco_pkg::NCO_OFS_ACC_LOW:   v = s.acc[7:0];
            nco_pkg::NCO_OFS_ACC_HIGH:  v = s.acc[15:8];
            nco_pkg::NCO_OFS_ACC_UPPER: v = {4'h0, s.acc[19:16]};
            nco_pkg::NCO_OFS_STEP_LOW:  v = s.step_buf[7:0];
            nco_pkg::NCO_OFS_STEP_HIGH: v = s.step_buf[15:8];
            nco_pkg::NCO_OFS_IRQ: begin
                v[nco_pkg::NCO_IRQ_FLAG] = s.flag;
                v[nco_pkg::NCO_IRQ_IE]   = s.ie;
                v[nco_pkg::NCO_IRQ_PERIPHERAL_IRQ_ENABLE] = s.peripheral_irq_enable;
                v[nco_pkg::NCO_IRQ_GIE]  = s.global_irq_enable;
            end
            default: v = 8'h00;
        endcase
        return {24'h00_0000, v};
    endfunction

    // Output level of the mode and polarity stages for a given state.
    function automatic logic out_level(input nco_pkg::nco_state_t s);
        logic m;
        m = s.pfm ? s.pulse_act : s.toggle;
        return s.pol ? m : ~m;
    endfunction

    // Selected source and its rising edge; fosc is this clock itself.
    // source decode
    always_comb begin
        case (q.cks)
            nco_pkg::NCO_SRC_HFOSC: src_now = q.hf_sync[1];
            nco_pkg::NCO_SRC_LC:    src_now = q.lc_sync[1];
            nco_pkg::NCO_SRC_EXT:   src_now = q.ext_sync[1];
            default:                src_now = 1'b1;
        endcase
    end

    assign tick = (q.cks == nco_pkg::NCO_SRC_FOSC) ? 1'b1
                                                   : (src_now & ~q.src_prev);

    // A request is served on the edge where waitrequest is already low.
    assign wr_go   = avs_write_in & ~q.wait_r;
    assign rd_go   = avs_read_in & ~avs_write_in;
    assign wr_lane = wr_go & avs_byteenable_in[0];
    assign wbyte   = avs_writedata_in[7:0];

    assign acc_wr  = wr_lane & ((avs_address_in == nco_pkg::NCO_OFS_ACC_LOW)
                     | (avs_address_in == nco_pkg::NCO_OFS_ACC_HIGH)
                     | (avs_address_in == nco_pkg::NCO_OFS_ACC_UPPER));
    assign step_wr = wr_lane & ((avs_address_in == nco_pkg::NCO_OFS_STEP_LOW)
                     | (avs_address_in == nco_pkg::NCO_OFS_STEP_HIGH));
    assign flag_clr = wr_lane & (avs_address_in == nco_pkg::NCO_OFS_IRQ)
                      & ~wbyte[nco_pkg::NCO_IRQ_FLAG];

    assign sum_w = {1'b0, q.acc} + {5'h00, q.step_act};
    assign carry = tick & q.en & sum_w[20];

    // Next-state logic for the whole block.
    always_comb begin
        d = q;
        // Two flops per asynchronous source; only stage two is read.
        d.hf_sync  = {q.hf_sync[0], high_freq_internal_osc_in};
        d.lc_sync  = {q.lc_sync[0], logic_cell_output_in};
        d.ext_sync = {q.ext_sync[0], external_clock_pin_in};
        d.src_prev = src_now;

        // Bus handshake: one wait cycle, then the answer edge.
        if ((avs_read_in | avs_write_in) & q.wait_r) begin
            d.wait_r = 1'b0;
            d.rdata  = rd_go ? reg_read(q, avs_address_in)
                             : nco_pkg::NCO_RDATA_RST;
        end else begin
            d.wait_r = 1'b1;
        end

        if (tick & q.en) begin
            d.acc = sum_w[19:0];
            if (q.step_pend) begin
                d.step_act  = q.step_buf;
                d.step_pend = 1'b0;
            end
        end

        if (carry) begin
            d.toggle = ~q.toggle;
        end

        if (tick & q.en) begin
            if (q.pulse_act) begin
                if (q.pulse_cnt == 7'h00) begin
                    d.pulse_act = 1'b0;
                end else begin
                    d.pulse_cnt = q.pulse_cnt - 7'h01;
                end
            end
            if (q.ovf_pend) begin
                d.pulse_act = 1'b1;
                d.pulse_cnt = 7'((8'h01 << q.pws) - 8'h01);
                d.ovf_pend  = 1'b0;
            end
            if (carry) begin
                d.ovf_pend = 1'b1;
            end
        end

        // Register writes; a byte write wins over a same-cycle addition.
        if (wr_lane) begin
            case (avs_address_in)
                nco_pkg::NCO_OFS_CTRL: begin
                    d.en  = wbyte[nco_pkg::NCO_CTRL_EN];
                    d.oe  = wbyte[nco_pkg::NCO_CTRL_OE];
                    d.pol = wbyte[nco_pkg::NCO_CTRL_POL];
                    d.pfm = wbyte[nco_pkg::NCO_CTRL_PFM];
                end
                nco_pkg::NCO_OFS_CLKSEL: begin
                    d.pws = wbyte[nco_pkg::NCO_CLK_PWS_LSB +: 3];
                    d.cks = wbyte[nco_pkg::NCO_CLK_CKS_LSB +: 2];
                end
                nco_pkg::NCO_OFS_ACC_LOW:   d.acc[7:0]   = wbyte;
                nco_pkg::NCO_OFS_ACC_HIGH:  d.acc[15:8]  = wbyte;
                nco_pkg::NCO_OFS_ACC_UPPER: d.acc[19:16] = wbyte[3:0];
                nco_pkg::NCO_OFS_STEP_LOW:  d.step_buf[7:0]  = wbyte;
                nco_pkg::NCO_OFS_STEP_HIGH: d.step_buf[15:8] = wbyte;
                nco_pkg::NCO_OFS_IRQ: begin
                    d.ie   = wbyte[nco_pkg::NCO_IRQ_IE];
                    d.peripheral_irq_enable = wbyte[nco_pkg::NCO_IRQ_PERIPHERAL_IRQ_ENABLE];
                    d.global_irq_enable  = wbyte[nco_pkg::NCO_IRQ_GIE];
                end
                default: d.en = q.en;
            endcase
        end

        if (step_wr) begin
            if (~q.en) begin
                d.step_act  = d.step_buf;
                d.step_pend = 1'b0;
            end else if (avs_address_in == nco_pkg::NCO_OFS_STEP_LOW) begin
                d.step_pend = 1'b1;
            end
        end

        if (flag_clr) begin
            d.flag = 1'b0;
        end
        if (carry | (q.ie & (d.pol != q.pol))) begin
            d.flag = 1'b1;
        end

        d.level = out_level(d);
        d.pin    = d.level;
        d.pin_oe = d.oe;
        d.irq = d.flag & d.en & d.ie & d.peripheral_irq_enable & d.global_irq_enable;
        d.keep_hf = d.en & (d.cks == nco_pkg::NCO_SRC_HFOSC);
    end

    // State register; nothing here depends on a sleep signal, so the
    // block runs on as long as the chosen source toggles.
    // reset clears all but wait_r and level, which load one
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            q        <= '0;
            q.wait_r <= 1'b1;
            // The zero state under active-low polarity is the inactive high
            // level; resetting it low would fake one active cycle.
            q.level  <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Every output comes straight from the state record.
    assign avs_readdata_out    = q.rdata;
    assign avs_waitrequest_out = q.wait_r;
    assign output_level_out    = q.level;
    assign pin_out             = q.pin;
    assign pin_oe_out          = q.pin_oe;
    assign irq_request_out     = q.irq;
    assign hf_osc_keep_on_out  = q.keep_hf;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_acc_add_step: assert property (
        (tick && q.en && !acc_wr) |=> (q.acc == $past(sum_w[19:0])))
        else $error("Accumulator did not add the increment.");

    a_idle_no_add: assert property (
        (!q.en && !acc_wr) |=> $stable(q.acc))
        else $error("Accumulator moved while disabled.");

    a_ovf_sets_flag: assert property (
        carry |=> q.flag)
        else $error("Overflow did not set the flag.");

    a_flag_sticky: assert property (
        (q.flag && !flag_clr) |=> q.flag)
        else $error("Flag dropped without a clear.");

    a_fdc_toggle: assert property (
        carry |=> (q.toggle != $past(q.toggle)))
        else $error("Fixed duty output did not toggle.");

    a_pulse_start: assert property (
        (tick && q.en && q.ovf_pend) |=> q.pulse_act)
        else $error("Pulse did not start after overflow.");

    a_polar_level: assert property (
        q.level == (q.pol ? (q.pfm ? q.pulse_act : q.toggle)
                          : !(q.pfm ? q.pulse_act : q.toggle)))
        else $error("Output level ignores polarity.");

    a_pin_gate: assert property (
        q.pin_oe == q.oe && (q.oe -> q.pin == q.level))
        else $error("Pin drive does not follow enable.");

    a_irq_gate: assert property (
        q.irq |-> (q.en && q.ie && q.peripheral_irq_enable && q.global_irq_enable && q.flag))
        else $error("Interrupt raised without all enables.");

    a_step_direct: assert property (
        (step_wr && !q.en) |=> (q.step_act == q.step_buf))
        else $error("Disabled increment write not applied.");

    a_bus_answer: assert property (
        ((avs_read_in || avs_write_in) && q.wait_r) |=> !q.wait_r ##1 q.wait_r)
        else $error("Bus answer not given in one cycle.");

    a_pol_irq_flag: assert property (
        (q.ie && (d.pol != q.pol)) |=> q.flag)
        else $error("Polarity change did not set the flag.");

    a_flag_clear: assert property (
        (flag_clr && !carry) |=> !q.flag)
        else $error("Flag not cleared by software.");

    a_step_hold: assert property (
        (q.en && !q.step_pend && step_wr
         && (avs_address_in == nco_pkg::NCO_OFS_STEP_HIGH))
        |=> $stable(q.step_act))
        else $error("High increment byte applied before the low byte.");

    a_step_load: assert property (
        (tick && q.en && q.step_pend)
        |=> (q.step_act == $past(q.step_buf)))
        else $error("Armed increment not loaded on the tick.");

    a_pulse_end: assert property (
        (tick && q.en && q.pulse_act && (q.pulse_cnt == 7'h00)
         && !q.ovf_pend) |=> !q.pulse_act)
        else $error("Pulse outlived its width.");

    a_irq_follow: assert property (
        (q.flag && q.en && q.ie && q.peripheral_irq_enable && q.global_irq_enable) |-> q.irq)
        else $error("Interrupt missing with all enables set.");

    a_keep_hf_on: assert property (
        q.keep_hf == (q.en && (q.cks == nco_pkg::NCO_SRC_HFOSC)))
        else $error("High-frequency source keep-on is wrong.");

    a_acc_byte_wr: assert property (
        (acc_wr && (avs_address_in == nco_pkg::NCO_OFS_ACC_UPPER))
        |=> (q.acc[19:16] == $past(wbyte[3:0])))
        else $error("Upper accumulator byte write lost.");

endmodule

/* File: nco_far_end.sv */
// Far-side model: clock sources for the oscillator and its output pin.
`timescale 1ns/100ps
module nco_far_end (
    // Clock and source run controls.
    input  wire logic        sys_clk_in,
    input  wire logic [2:0]  run_in,
    // Pin from the oscillator.
    input  wire logic        pin_in,
    input  wire logic        pin_oe_in,
    // Sources (bit 0 internal, 1 logic cell, 2 pin) and resolved pin.
    output logic      [2:0]  src_out,
    output logic             pin_wire_out,
    output logic      [15:0] rise_cnt_out
);
    logic [1:0] div_q;

    // pin resolve: the pin has a pull-down, so an undriven pin is low.
    assign pin_wire_out = pin_oe_in ? pin_in : 1'b0;

    // A running source toggles every fourth cycle, well below half the
    // system rate; a stopped one stands still and rises are counted.
    initial begin
        src_out = 3'h0;
        div_q = 2'h0;
        rise_cnt_out = 16'h0000;
    end
    always @(posedge sys_clk_in) begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h3) begin
            src_out <= src_out ^ run_in;
            if ((run_in & ~src_out) != 3'h0) begin
                rise_cnt_out <= rise_cnt_out + 16'h0001;
            end
        end
    end
endmodule

/* File: tb_top.sv */
// Self-checking testbench for the oscillator block.
`timescale 1ns/100ps
module tb_top;
    logic        sys_clk_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [4:0]  avs_address_in = 5'h00;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic [2:0]  src;
    logic [2:0]  run_q = 3'h0;
    logic        output_level_out;
    logic        pin_out;
    logic        pin_oe_out;
    logic        pin_wire;
    logic        irq_request_out;
    logic        hf_osc_keep_on_out;
    logic [15:0] rises;
    logic [15:0] base;
    logic [31:0] n;
    logic [7:0]  q;
    int          fails = 0;
    int          comparisons = 0;

    // Free-running system clock, 50 ns period.
    always #25 sys_clk_in = ~sys_clk_in;

    nco_top u_nco_top (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(4'h1), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .high_freq_internal_osc_in(src[0]), .logic_cell_output_in(src[1]),
        .external_clock_pin_in(src[2]), .output_level_out(output_level_out),
        .pin_out(pin_out), .pin_oe_out(pin_oe_out),
        .irq_request_out(irq_request_out),
        .hf_osc_keep_on_out(hf_osc_keep_on_out));

    nco_far_end u_nco_far_end (
        .sys_clk_in(sys_clk_in), .run_in(run_q), .pin_in(pin_out),
        .pin_oe_in(pin_oe_out), .src_out(src), .pin_wire_out(pin_wire),
        .rise_cnt_out(rises));

    // Compare one result and count it.
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon-MM transfer; held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [7:0] d);
        int k;
        k = 0;
        @(posedge sys_clk_in);
        avs_address_in <= a;
        avs_writedata_in <= {24'h000000, d};
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        do begin
            @(posedge sys_clk_in);
            k++;
        end while (avs_waitrequest_out !== 1'b0 && k < 50);
        if (k >= 50) begin
            fails++;
            $display("[ERR] waitrequest expected 0 seen %b",
                     avs_waitrequest_out);
        end
        q = avs_readdata_out[7:0];
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        // Outputs launched by the write settle before anyone looks.
        @(posedge sys_clk_in);
    endtask

    task automatic rc(input string what, input logic [4:0] a,
                      input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(what, {24'h0, exp}, {24'h0, q});
    endtask

    // Cycles that the output level stays at lvl, measured from a fresh edge.
    task automatic span(input logic lvl);
        int k;
        k = 0;
        n = 0;
        while (output_level_out === lvl && k < 400) begin
            @(posedge sys_clk_in);
            k++;
        end
        while (output_level_out !== lvl && k < 800) begin
            @(posedge sys_clk_in);
            k++;
        end
        while (output_level_out === lvl && n < 400) begin
            @(posedge sys_clk_in);
            n++;
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic end_of_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs well under 20000 cycles.
    initial begin
        #(50 * 20000);
        fails++;
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        // The level bit reads high: idle output under active-low polarity.
        for (int i = 0; i < 8; i++) begin
            rc("reset value", 5'(i * 4), (i == 0) ? 8'h20 : 8'h00);
        end
        chk("irq after reset", 32'h0, {31'h0, irq_request_out});
        // Accumulator bytes; the upper nibble of the top byte reads zero.
        wr(nco_pkg::NCO_OFS_ACC_LOW, 8'h5a);
        wr(nco_pkg::NCO_OFS_ACC_HIGH, 8'ha5);
        wr(nco_pkg::NCO_OFS_ACC_UPPER, 8'hff);
        rc("acc low", nco_pkg::NCO_OFS_ACC_LOW, 8'h5a);
        rc("acc high", nco_pkg::NCO_OFS_ACC_HIGH, 8'ha5);
        rc("acc upper", nco_pkg::NCO_OFS_ACC_UPPER, 8'h0f);
        wr(5'h02, 8'hff);
        rc("unmapped", 5'h02, 8'h00);
        // Disabled: low byte first still loads at once; half period 32 ticks.
        wr(nco_pkg::NCO_OFS_STEP_LOW, 8'h00);
        wr(nco_pkg::NCO_OFS_STEP_HIGH, 8'h80);
        rc("step low", nco_pkg::NCO_OFS_STEP_LOW, 8'h00);
        rc("step high", nco_pkg::NCO_OFS_STEP_HIGH, 8'h80);
        wr(nco_pkg::NCO_OFS_CLKSEL, 8'h01);
        wr(nco_pkg::NCO_OFS_CTRL, 8'h80);
        span(1'b1);
        chk("duty high", 32'd32, n);
        span(1'b0);
        chk("duty low", 32'd32, n);
        // Enabled: a lone high-byte write must wait for the low byte.
        wr(nco_pkg::NCO_OFS_STEP_HIGH, 8'h40);
        span(1'b1);
        chk("high only", 32'd32, n);
        wr(nco_pkg::NCO_OFS_STEP_LOW, 8'h00);
        span(1'b1);
        chk("after low", 32'd64, n);
        // Disabled: no additions.
        wr(nco_pkg::NCO_OFS_CTRL, 8'h00);
        wr(nco_pkg::NCO_OFS_ACC_HIGH, 8'h00);
        wr(nco_pkg::NCO_OFS_ACC_UPPER, 8'h00);
        repeat (20) @(posedge sys_clk_in);
        rc("acc idle", nco_pkg::NCO_OFS_ACC_UPPER, 8'h00);
        // Interrupt flag and the four enables.
        wr(nco_pkg::NCO_OFS_IRQ, 8'h06);
        wr(nco_pkg::NCO_OFS_CTRL, 8'h80);
        repeat (100) @(posedge sys_clk_in);
        chk("irq no global", 32'h0, {31'h0, irq_request_out});
        wr(nco_pkg::NCO_OFS_CTRL, 8'h00);
        rc("flag set", nco_pkg::NCO_OFS_IRQ, 8'h07);
        wr(nco_pkg::NCO_OFS_IRQ, 8'h0f);
        chk("irq disabled", 32'h0, {31'h0, irq_request_out});
        rc("flag held", nco_pkg::NCO_OFS_IRQ, 8'h0f);
        wr(nco_pkg::NCO_OFS_IRQ, 8'h0e);
        rc("flag cleared", nco_pkg::NCO_OFS_IRQ, 8'h0e);
        wr(nco_pkg::NCO_OFS_CTRL, 8'h80);
        repeat (80) @(posedge sys_clk_in);
        chk("irq all set", 32'h1, {31'h0, irq_request_out});
        wr(nco_pkg::NCO_OFS_IRQ, 8'h00);
        // Pulse mode, active high, every width code; 256-tick period.
        // width below period
        wr(nco_pkg::NCO_OFS_STEP_HIGH, 8'h10);
        wr(nco_pkg::NCO_OFS_STEP_LOW, 8'h00);
        for (int k = 0; k < 8; k++) begin
            wr(nco_pkg::NCO_OFS_CLKSEL, {3'(k), 5'h01});
            wr(nco_pkg::NCO_OFS_CTRL, 8'h91);
            span(1'b1);
            chk("pulse width", 32'd1 << k, n);
        end
        wr(nco_pkg::NCO_OFS_CTRL, 8'h81);
        span(1'b0);
        chk("active low width", 32'd128, n);
        // Stopped output, pin driven, then released.
        wr(nco_pkg::NCO_OFS_CTRL, 8'h40);
        bus(1'b0, nco_pkg::NCO_OFS_CTRL, 8'h00);
        chk("level bit", {31'h0, output_level_out}, {31'h0, q[5]});
        chk("pin oe", 32'h1, {31'h0, pin_oe_out});
        chk("pin level", {31'h0, output_level_out}, {31'h0, pin_wire});
        wr(nco_pkg::NCO_OFS_CTRL, 8'h00);
        chk("pin off", 32'h0, {31'h0, pin_oe_out});
        // Each outside source: step 1, count its rising edges.
        for (int s = 0; s < 4; s++) begin
            if (s != 1) begin
                wr(nco_pkg::NCO_OFS_ACC_LOW, 8'h00);
                wr(nco_pkg::NCO_OFS_STEP_HIGH, 8'h00);
                wr(nco_pkg::NCO_OFS_STEP_LOW, 8'h01);
                wr(nco_pkg::NCO_OFS_CLKSEL, 8'(s));
                wr(nco_pkg::NCO_OFS_CTRL, 8'h80);
                chk("keep hf", {31'h0, s == 0},
                    {31'h0, hf_osc_keep_on_out});
                base = rises;
                run_q <= 3'(1 << (s == 0 ? 0 : s - 1));
                repeat (80) @(posedge sys_clk_in);
                run_q <= 3'h0;
                repeat (12) @(posedge sys_clk_in);
                wr(nco_pkg::NCO_OFS_CTRL, 8'h00);
                rc("source edges", nco_pkg::NCO_OFS_ACC_LOW,
                   8'(rises - base));
            end
        end
        // Polarity flip with the local enable set raises the flag.
        wr(nco_pkg::NCO_OFS_IRQ, 8'h02);
        wr(nco_pkg::NCO_OFS_CTRL, 8'h10);
        rc("polarity flag", nco_pkg::NCO_OFS_IRQ, 8'h03);
        end_of_test();
    end
endmodule
